// *** shared/period_match_timer8_pkg.sv ***
package period_match_timer8_pkg;

   localparam int          ADDR_WIDTH     = 5;
   localparam int          DATA_WIDTH     = 32;
   localparam int          CNT_WIDTH      = 8;
   localparam int          PRE_WIDTH      = 6;
   localparam int          POST_WIDTH     = 4;

   localparam logic [4:0]  OFF_COUNT      = 5'h00;
   localparam logic [4:0]  OFF_PERIOD     = 5'h04;
   localparam logic [4:0]  OFF_CONTROL    = 5'h08;
   localparam logic [4:0]  OFF_STATUS     = 5'h0c;
   localparam logic [4:0]  OFF_MASK       = 5'h10;

   localparam int          SEL_COUNT      = 0;
   localparam int          SEL_PERIOD     = 1;
   localparam int          SEL_CONTROL    = 2;
   localparam int          SEL_STATUS     = 3;
   localparam int          SEL_MASK       = 4;
   localparam int          NUM_REGS       = 5;

   localparam int          PRESCALE_LSB   = 0;
   localparam int          RUN_BIT        = 2;
   localparam int          POSTSCALE_LSB  = 3;
   localparam int          CTRL_WIDTH     = 7;
   localparam int          MATCH_FLAG_BIT = 0;

   localparam logic [7:0]  COUNT_RESET    = 8'h00;
   localparam logic [7:0]  PERIOD_RESET   = 8'hff;
   localparam logic [6:0]  CONTROL_RESET  = 7'h00;

   // system clock 100 MHz, instruction clock is a quarter of it
   localparam int          FOSC_MHZ       = 100;
   localparam int          INSTR_DIV      = 4;
   localparam logic [1:0]  INSTR_LAST     = 2'(INSTR_DIV - 1);

   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   typedef struct packed {
      logic [3:0] postscale_select;
      logic       timer_run;
      logic [1:0] prescale_select;
   } ctrl_type;

   typedef struct packed {
      logic [DATA_WIDTH-1:0] data;
      logic [1:0]            resp;
   } rd_ans_type;

   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_TAKE = 3'b010,
      BUS_RESP = 3'b100
   } bus_state_type;

endpackage

// *** rtl/prescale_divider.sv ***
`timescale 1ns/1ps
module prescale_divider
   import period_match_timer8_pkg::*;
#(
   parameter int DIV_WIDTH = PRE_WIDTH
) (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic                 ce,
   input  wire logic                 clear,
   input  wire logic                 tick_in,
   input  wire logic [1:0]           sel,
   output logic                      tick_out,
   output logic [DIV_WIDTH-1:0]      count
);

   logic [DIV_WIDTH-1:0] cnt_reg;
   logic [DIV_WIDTH-1:0] cnt_next;
   logic [DIV_WIDTH-1:0] terminal;

   // ratios 1, 4, 16, 64 need six bits at the largest code
   if (DIV_WIDTH < PRE_WIDTH) begin : g_width_check
      $error("prescale_divider: DIV_WIDTH too small for ratio 64");
   end

   assign terminal = DIV_WIDTH'((64'd1 << {sel, 1'b0}) - 64'd1);
   assign tick_out = tick_in & ~clear & (cnt_reg == terminal);
   assign count    = cnt_reg;

   always_comb begin
      cnt_next = cnt_reg;
      if (clear) begin
         cnt_next = '0;
      end else if (tick_out) begin
         cnt_next = '0;
      end else if (tick_in) begin
         cnt_next = DIV_WIDTH'(cnt_reg + 1'b1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_reg <= '0;
      end else if (ce) begin
         cnt_reg <= cnt_next;
      end
   end

endmodule

// *** rtl/period_match_timer8.sv ***
`timescale 1ns/1ps
// How it works
// - timer runs from system clock divided by four
// - count increments from zero on prescaled ticks
// - prescale codes divide by 1, 4, 16, 64
// - compare count with period, pulse on equality
// - after a match count restarts at zero
// - software reads and writes count and period
// - reset clears count, period goes all ones
// - count write, control write, reset clear scalers
// - control write leaves count value untouched
// - matches advance postscaler, terminal sets latched flag
// - enable gates interrupt, flag latches regardless
// - postscale code N gives one flag per N+1
// - unscaled match pulse exported for pwm
// - match output offered as spi shift clock
// - sleep stops counting, registers hold values
module period_match_timer8
   import period_match_timer8_pkg::*;
#(
   parameter int COUNT_WIDTH = CNT_WIDTH
) (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic                  ce,
   input  wire logic                  sleep_req,
   input  wire logic [ADDR_WIDTH-1:0] awaddr,
   input  wire logic [2:0]            awprot,
   input  wire logic                  awvalid,
   output logic                       awready,
   input  wire logic [DATA_WIDTH-1:0] wdata,
   input  wire logic [3:0]            wstrb,
   input  wire logic                  wvalid,
   output logic                       wready,
   output logic [1:0]                 bresp,
   output logic                       bvalid,
   input  wire logic                  bready,
   input  wire logic [ADDR_WIDTH-1:0] araddr,
   input  wire logic [2:0]            arprot,
   input  wire logic                  arvalid,
   output logic                       arready,
   output logic [DATA_WIDTH-1:0]      rdata,
   output logic [1:0]                 rresp,
   output logic                       rvalid,
   input  wire logic                  rready,
   output logic                       match_pulse,
   output logic                       spi_shift_clk,
   output logic                       irq
);

   if (COUNT_WIDTH < 1 || COUNT_WIDTH > CNT_WIDTH) begin : g_width_check
      $error("period_match_timer8: COUNT_WIDTH must be 1 to 8");
   end

   function automatic logic [NUM_REGS-1:0] reg_select(input logic [ADDR_WIDTH-1:0] a);
      logic [NUM_REGS-1:0] s;
      s              = '0;
      s[SEL_COUNT]   = (a == OFF_COUNT);
      s[SEL_PERIOD]  = (a == OFF_PERIOD);
      s[SEL_CONTROL] = (a == OFF_CONTROL);
      s[SEL_STATUS]  = (a == OFF_STATUS);
      s[SEL_MASK]    = (a == OFF_MASK);
      return s;
   endfunction

   bus_state_type          wr_state_reg;
   bus_state_type          wr_state_next;
   bus_state_type          rd_state_reg;
   bus_state_type          rd_state_next;
   logic [1:0]             bresp_reg;
   rd_ans_type             rd_ans_reg;
   rd_ans_type             rd_ans_next;

   logic [1:0]             instr_div_reg;
   ctrl_type               ctrl_reg;
   logic [COUNT_WIDTH-1:0] count_reg;
   logic [COUNT_WIDTH-1:0] count_next;
   logic [COUNT_WIDTH-1:0] period_reg;
   logic [POST_WIDTH-1:0]  post_cnt_reg;
   logic [POST_WIDTH-1:0]  post_cnt_next;
   logic                   match_irq_flag_reg;
   logic                   match_irq_flag_next;
   logic                   match_irq_enable_reg;
   logic                   match_pulse_reg;
   logic                   spi_clk_reg;
   logic                   irq_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // register bus decode

   logic [NUM_REGS-1:0]    wr_sel;
   logic [NUM_REGS-1:0]    rd_sel;
   logic                   wr_fire;
   logic                   wr_en;
   logic                   wr_count;
   logic                   wr_period;
   logic                   wr_control;
   logic                   wr_status;
   logic                   wr_mask;
   logic                   rd_fire;
   logic [DATA_WIDTH-1:0]  rd_word;

   assign wr_sel     = reg_select(awaddr);
   assign rd_sel     = reg_select(araddr);
   assign wr_fire    = wr_state_reg[1] & awvalid & wvalid;
   // data is one byte wide, only lane 0 carries it
   assign wr_en      = wr_fire & wstrb[0];
   assign wr_count   = wr_en & wr_sel[SEL_COUNT];
   assign wr_period  = wr_en & wr_sel[SEL_PERIOD];
   assign wr_control = wr_en & wr_sel[SEL_CONTROL];
   assign wr_status  = wr_en & wr_sel[SEL_STATUS];
   assign wr_mask    = wr_en & wr_sel[SEL_MASK];
   assign rd_fire    = rd_state_reg[1] & arvalid;

   assign rd_word =
      ({DATA_WIDTH{rd_sel[SEL_COUNT]}}   & DATA_WIDTH'(count_reg))   |
      ({DATA_WIDTH{rd_sel[SEL_PERIOD]}}  & DATA_WIDTH'(period_reg))  |
      ({DATA_WIDTH{rd_sel[SEL_CONTROL]}} & DATA_WIDTH'(ctrl_reg))    |
      ({DATA_WIDTH{rd_sel[SEL_STATUS]}}  & DATA_WIDTH'(match_irq_flag_reg)) |
      ({DATA_WIDTH{rd_sel[SEL_MASK]}}    & DATA_WIDTH'(match_irq_enable_reg));

   always_comb begin
      wr_state_next = wr_state_reg;
      case (wr_state_reg)
         BUS_IDLE: begin
            if (awvalid && wvalid) begin
               wr_state_next = BUS_TAKE;
            end
         end
         BUS_TAKE: begin
            if (wr_fire) begin
               wr_state_next = BUS_RESP;
            end
         end
         BUS_RESP: begin
            if (bready) begin
               wr_state_next = BUS_IDLE;
            end
         end
         default: wr_state_next = BUS_IDLE;
      endcase
   end

   always_comb begin
      rd_state_next = rd_state_reg;
      rd_ans_next   = rd_ans_reg;
      case (rd_state_reg)
         BUS_IDLE: begin
            if (arvalid) begin
               rd_state_next = BUS_TAKE;
            end
         end
         BUS_TAKE: begin
            if (rd_fire) begin
               rd_state_next    = BUS_RESP;
               rd_ans_next.data = rd_word;
               rd_ans_next.resp = (|rd_sel) ? RESP_OKAY : RESP_SLVERR;
            end
         end
         BUS_RESP: begin
            if (rready) begin
               rd_state_next = BUS_IDLE;
            end
         end
         default: rd_state_next = BUS_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_reg <= BUS_IDLE;
         rd_state_reg <= BUS_IDLE;
         bresp_reg    <= RESP_OKAY;
         rd_ans_reg   <= '0;
      end else if (ce) begin
         wr_state_reg <= wr_state_next;
         rd_state_reg <= rd_state_next;
         rd_ans_reg   <= rd_ans_next;
         if (wr_fire) begin
            bresp_reg <= (|wr_sel) ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // one-hot state bits are the handshake flops themselves
   assign awready = wr_state_reg[1];
   assign wready  = wr_state_reg[1];
   assign bvalid  = wr_state_reg[2];
   assign bresp   = bresp_reg;
   assign arready = rd_state_reg[1];
   assign rvalid  = rd_state_reg[2];
   assign rdata   = rd_ans_reg.data;
   assign rresp   = rd_ans_reg.resp;

   ////////////////////////////////////////////////////////////////////////////////
   // instruction clock and prescaler

   logic                   instr_tick;
   logic                   run_tick;
   logic                   timer_tick;
   logic                   scaler_clear;
   logic [PRE_WIDTH-1:0]   pre_count;

   // a tick enable, not a derived clock, keeps one clock domain
   assign instr_tick   = ce & (instr_div_reg == INSTR_LAST);
   assign run_tick     = instr_tick & ctrl_reg.timer_run & ~sleep_req;
   assign scaler_clear = wr_count | wr_control;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         instr_div_reg <= '0;
      end else if (ce) begin
         instr_div_reg <= 2'(instr_div_reg + 1'b1);
      end
   end

   prescale_divider #(
      .DIV_WIDTH (PRE_WIDTH)
   ) u_prescale (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .ce       (ce),
      .clear    (scaler_clear),
      .tick_in  (run_tick),
      .sel      (ctrl_reg.prescale_select),
      .tick_out (timer_tick),
      .count    (pre_count)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // count, compare, postscaler

   logic                   hit;
   logic                   post_hit;

   assign hit      = timer_tick & (count_reg == period_reg);
   assign post_hit = hit & (post_cnt_reg == ctrl_reg.postscale_select);

   always_comb begin
      count_next = count_reg;
      if (wr_count) begin
         count_next = wdata[COUNT_WIDTH-1:0];
      end else if (hit) begin
         count_next = '0;
      end else if (timer_tick) begin
         count_next = COUNT_WIDTH'(count_reg + 1'b1);
      end
   end

   always_comb begin
      post_cnt_next = post_cnt_reg;
      if (scaler_clear) begin
         post_cnt_next = '0;
      end else if (post_hit) begin
         post_cnt_next = '0;
      end else if (hit) begin
         post_cnt_next = POST_WIDTH'(post_cnt_reg + 1'b1);
      end
   end

   // a match in the clearing cycle still sets the flag
   assign match_irq_flag_next = post_hit |
      (match_irq_flag_reg & ~(wr_status & wdata[MATCH_FLAG_BIT]));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_reg    <= COUNT_WIDTH'(COUNT_RESET);
         period_reg   <= COUNT_WIDTH'(PERIOD_RESET);
         ctrl_reg     <= CONTROL_RESET;
         post_cnt_reg <= '0;
      end else if (ce) begin
         count_reg    <= count_next;
         post_cnt_reg <= post_cnt_next;
         if (wr_period) begin
            period_reg <= wdata[COUNT_WIDTH-1:0];
         end
         if (wr_control) begin
            ctrl_reg <= ctrl_type'(wdata[CTRL_WIDTH-1:0]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs and interrupt

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         match_irq_flag_reg   <= 1'b0;
         match_irq_enable_reg <= 1'b0;
         match_pulse_reg      <= 1'b0;
         spi_clk_reg          <= 1'b0;
         irq_reg              <= 1'b0;
      end else if (ce) begin
         match_irq_flag_reg <= match_irq_flag_next;
         if (wr_mask) begin
            match_irq_enable_reg <= wdata[MATCH_FLAG_BIT];
         end
         match_pulse_reg <= hit;
         spi_clk_reg     <= spi_clk_reg ^ hit;
         irq_reg         <= match_irq_flag_reg & match_irq_enable_reg;
      end
   end

   assign match_pulse   = match_pulse_reg;
   assign spi_shift_clk = spi_clk_reg;
   assign irq           = irq_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_INSTR_SPACING: assert property (
      instr_tick |=> (!instr_tick) [*3])
      else $error("instruction ticks closer than four cycles");

   AST_COUNT_STEP: assert property (
      timer_tick && !hit && !wr_count |=>
         count_reg == COUNT_WIDTH'($past(count_reg) + 1'b1))
      else $error("count did not step by one");

   AST_PRESCALE_ONE: assert property (
      ctrl_reg.prescale_select == 2'h0 && run_tick && !scaler_clear |-> timer_tick)
      else $error("divide by one missed a tick");

   AST_MATCH_RELOAD: assert property (
      hit |=> match_pulse_reg && (count_reg == '0 || $past(wr_count)))
      else $error("match did not pulse and reload");

   AST_RESET_VALUES: assert property (
      $rose(aresetn) |-> count_reg == '0 && period_reg == '1)
      else $error("wrong values after reset");

   AST_SCALER_CLEAR: assert property (
      scaler_clear && ce |=> pre_count == '0 && post_cnt_reg == '0)
      else $error("scalers not cleared by write");

   AST_CTRL_KEEPS: assert property (
      wr_control |=> $stable(count_reg))
      else $error("control write changed count");

   AST_FLAG_SET: assert property (
      post_hit |=> match_irq_flag_reg && post_cnt_reg == '0)
      else $error("postscaler terminal did not set flag");

   AST_IRQ_GATE: assert property (
      ce |=> irq_reg == $past(match_irq_flag_reg && match_irq_enable_reg))
      else $error("interrupt not gated by enable");

   AST_STOP_HOLD: assert property (
      (!ctrl_reg.timer_run || sleep_req) && !wr_en && ce |=>
         $stable(count_reg) && $stable(period_reg))
      else $error("stopped timer changed registers");

   AST_FLAG_HOLD: assert property (
      match_irq_flag_reg && !wr_status |=> match_irq_flag_reg)
      else $error("flag dropped without a clear");

   AST_SPI_TOGGLE: assert property (
      hit |=> spi_clk_reg != $past(spi_clk_reg))
      else $error("shift clock did not toggle on match");

   COV_MATCH_SLOW: cover property (hit && ctrl_reg.prescale_select == 2'h3);
   COV_POST_16:    cover property (post_hit && ctrl_reg.postscale_select == 4'hf);
   COV_WRITE_RESP: cover property (wr_fire ##1 bvalid);
   COV_SLEEP_RUN:  cover property (sleep_req && ctrl_reg.timer_run && instr_tick);

endmodule

// *** tb/tb_period_match_timer8.sv ***
`timescale 1ns/1ps
module tb_period_match_timer8;
   import period_match_timer8_pkg::*;

   logic                  aclk;
   logic                  aresetn;
   logic                  ce;
   logic                  sleep_req;
   logic [ADDR_WIDTH-1:0] awaddr;
   logic [2:0]            awprot;
   logic                  awvalid;
   logic                  awready;
   logic [DATA_WIDTH-1:0] wdata;
   logic [3:0]            wstrb;
   logic                  wvalid;
   logic                  wready;
   logic [1:0]            bresp;
   logic                  bvalid;
   logic                  bready;
   logic [ADDR_WIDTH-1:0] araddr;
   logic [2:0]            arprot;
   logic                  arvalid;
   logic                  arready;
   logic [DATA_WIDTH-1:0] rdata;
   logic [1:0]            rresp;
   logic                  rvalid;
   logic                  rready;
   logic                  match_pulse;
   logic                  spi_shift_clk;
   logic                  irq;
   int                    errors = 0;
   int                    total_checks = 0;
   int                    match_cnt = 0;
   int                    base;

   period_match_timer8 u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .sleep_req(sleep_req),
      .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .match_pulse(match_pulse), .spi_shift_clk(spi_shift_clk), .irq(irq));

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // counts unscaled matches seen on the time base output
   always @(posedge aclk) begin
      if (match_pulse === 1'b1) match_cnt <= match_cnt + 1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task summarize;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task check(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task guard(input int n, input int lim, input string what);
      if (n >= lim) begin
         errors++;
         $display("Error %s timed out", what);
         summarize();
      end
   endtask

   task wr(input logic [4:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
      int n;
      logic [1:0] resp;
      n = 0;
      awaddr <= a;
      wdata <= {24'h0, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin @(posedge aclk); n++; end while (!(awready === 1'b1 && wready === 1'b1) && n < 50);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do begin @(posedge aclk); n++; end while (bvalid !== 1'b1 && n < 50);
      resp = bresp;
      bready <= 1'b0;
      guard(n, 50, "write response");
      @(posedge aclk);
      check("bresp", {30'h0, er}, {30'h0, resp});
   endtask

   task rd(input logic [4:0] a, input logic [7:0] exp, input logic [1:0] er);
      int n;
      logic [31:0] data;
      logic [1:0] resp;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin @(posedge aclk); n++; end while (arready !== 1'b1 && n < 50);
      arvalid <= 1'b0;
      do begin @(posedge aclk); n++; end while (rvalid !== 1'b1 && n < 50);
      data = rdata;
      resp = rresp;
      rready <= 1'b0;
      guard(n, 50, "read data");
      @(posedge aclk);
      check("rdata", {24'h0, exp}, data);
      check("rresp", {30'h0, er}, {30'h0, resp});
   endtask

   // gap between two matches, and the shift clock must flip once per match
   task gap(input int exp);
      int n;
      logic s;
      n = 0;
      do begin @(posedge aclk); n++; end while (match_pulse !== 1'b1 && n < 2000);
      guard(n, 2000, "first match");
      s = spi_shift_clk;
      n = 0;
      do begin @(posedge aclk); n++; end while (match_pulse !== 1'b1 && n < 2000);
      guard(n, 2000, "second match");
      check("match gap", exp, n);
      check("spi shift clock", {31'h0, ~s}, {31'h0, spi_shift_clk});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      int n;
      aresetn = 1'b0; ce = 1'b1; sleep_req = 1'b0; awaddr = '0; awprot = 3'h0; awvalid = 1'b0;
      wdata = '0; wstrb = 4'h0; wvalid = 1'b0; bready = 1'b0; araddr = '0; arprot = 3'h0;
      arvalid = 1'b0; rready = 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(OFF_COUNT, 8'h00, RESP_OKAY);
      rd(OFF_PERIOD, 8'hff, RESP_OKAY);
      rd(OFF_CONTROL, 8'h00, RESP_OKAY);
      rd(OFF_STATUS, 8'h00, RESP_OKAY);
      rd(OFF_MASK, 8'h00, RESP_OKAY);
      rd(5'h14, 8'h00, RESP_SLVERR);
      wr(5'h14, 8'h55, 4'h1, RESP_SLVERR);
      $display("test reset and map done");
      wr(OFF_PERIOD, 8'h5a, 4'h1, RESP_OKAY);
      rd(OFF_PERIOD, 8'h5a, RESP_OKAY);
      wr(OFF_COUNT, 8'h21, 4'h1, RESP_OKAY);
      rd(OFF_COUNT, 8'h21, RESP_OKAY);
      wr(OFF_PERIOD, 8'h00, 4'h0, RESP_OKAY);
      rd(OFF_PERIOD, 8'h5a, RESP_OKAY);
      wr(OFF_CONTROL, 8'hf8, 4'h1, RESP_OKAY);
      rd(OFF_CONTROL, 8'h78, RESP_OKAY);
      rd(OFF_COUNT, 8'h21, RESP_OKAY);
      $display("test register access done");
      sleep_req <= 1'b1;
      wr(OFF_CONTROL, 8'h04, 4'h1, RESP_OKAY);
      repeat (40) @(posedge aclk);
      rd(OFF_COUNT, 8'h21, RESP_OKAY);
      rd(OFF_PERIOD, 8'h5a, RESP_OKAY);
      sleep_req <= 1'b0;
      $display("test sleep done");
      wr(OFF_PERIOD, 8'h02, 4'h1, RESP_OKAY);
      wr(OFF_COUNT, 8'h00, 4'h1, RESP_OKAY);
      for (int k = 0; k < 4; k++) begin
         wr(OFF_CONTROL, {5'h01, 3'(k)} | 8'h04, 4'h1, RESP_OKAY);
         gap(3 * INSTR_DIV * (1 << (2 * k)));
      end
      $display("test prescaler done");
      wr(OFF_PERIOD, 8'h00, 4'h1, RESP_OKAY);
      wr(OFF_MASK, 8'h01, 4'h1, RESP_OKAY);
      for (int p = 0; p < 16; p++) begin
         wr(OFF_CONTROL, {1'b0, 4'(p), 3'b000}, 4'h1, RESP_OKAY);
         wr(OFF_STATUS, 8'h01, 4'h1, RESP_OKAY);
         base = match_cnt;
         wr(OFF_CONTROL, {1'b0, 4'(p), 3'b100}, 4'h1, RESP_OKAY);
         n = 0;
         do begin @(posedge aclk); n++; end while (irq !== 1'b1 && n < 300);
         guard(n, 300, "interrupt");
         check("matches per flag", p + 1, match_cnt - base);
      end
      $display("test postscaler done");
      wr(OFF_CONTROL, 8'h00, 4'h1, RESP_OKAY);
      wr(OFF_STATUS, 8'h00, 4'h1, RESP_OKAY);
      rd(OFF_STATUS, 8'h01, RESP_OKAY);
      wr(OFF_MASK, 8'h00, 4'h1, RESP_OKAY);
      repeat (3) @(posedge aclk);
      check("irq masked", 32'h0, irq);
      rd(OFF_STATUS, 8'h01, RESP_OKAY);
      wr(OFF_MASK, 8'h01, 4'h1, RESP_OKAY);
      repeat (3) @(posedge aclk);
      check("irq unmasked", 32'h1, irq);
      wr(OFF_STATUS, 8'h01, 4'h1, RESP_OKAY);
      rd(OFF_STATUS, 8'h00, RESP_OKAY);
      repeat (3) @(posedge aclk);
      check("irq cleared", 32'h0, irq);
      $display("test interrupt done");
      wr(OFF_PERIOD, 8'h02, 4'h1, RESP_OKAY);
      wr(OFF_CONTROL, 8'h04, 4'h1, RESP_OKAY);
      n = 0;
      do begin @(posedge aclk); n++; end while (match_pulse !== 1'b1 && n < 100);
      guard(n, 100, "match before freeze");
      // a freeze that leaks would shift the next match off its 12-cycle slot
      ce <= 1'b0;
      repeat (40) @(posedge aclk);
      ce <= 1'b1;
      n = 0;
      do begin @(posedge aclk); n++; end while (match_pulse !== 1'b1 && n < 100);
      guard(n, 100, "match after freeze");
      check("frozen match gap", 3 * INSTR_DIV, n);
      $display("test clock enable done");
      wr(OFF_PERIOD, 8'h40, 4'h1, RESP_OKAY);
      wr(OFF_CONTROL, 8'h07, 4'h1, RESP_OKAY);
      repeat (50) @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(OFF_COUNT, 8'h00, RESP_OKAY);
      rd(OFF_PERIOD, 8'hff, RESP_OKAY);
      rd(OFF_CONTROL, 8'h00, RESP_OKAY);
      $display("test second reset done");
      summarize();
   end
endmodule
